/* pkg/hdlc_sched_pkg.sv */
// Constants and state types of the HDLC FIFO transfer scheduler.
// Assumes a single device clock shared by engines, FIFO and DMA.
`default_nettype none

package hdlc_sched_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NPORT = 16;
  localparam int PORT_W = 4;
  localparam int FAST_PORTS = 2;
  localparam int NCHAN = 256;
  localparam int CH_W = 8;
  localparam int WORD_W = 32;
  localparam int BYTE_W = 8;
  localparam int FIFO_BYTES = 16384;
  localparam int BLOCK_BYTES = 16;
  localparam int REGION_BLOCKS = 4;
  localparam int REGION_WORDS = REGION_BLOCKS * BLOCK_BYTES / 4;
  localparam int PTR_W = 4;
  localparam int LVL_W = 5;
  localparam int MEM_AW = 12;
  localparam int MEM_DW = WORD_W + 1;
  localparam int BURST_MAX = 256;
  localparam int BURST_W = 9;
  localparam int BIDX_W = 2;
  localparam int RXBUF_W = CH_W + 1 + MEM_DW;

  // ----------------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------------
  localparam logic [LVL_W-1:0] LEVEL_RST = 5'h00;
  localparam logic [PTR_W-1:0] PTR_RST = 4'h0;
  localparam logic [LVL_W-1:0] REGION_FULL = 5'h10;
  localparam logic [BURST_W-1:0] BURST_LAST = 9'h0FF;
  localparam logic [BIDX_W-1:0] BIDX_LAST = 2'h3;
  localparam logic SCHED_RR = 1'b0;

  // ----------------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    RXD_IDLE = 2'b01,
    RXD_BURST = 2'b10
  } rxd_state_t;

  typedef enum logic [1:0] {
    TXD_IDLE = 2'b01,
    TXD_BURST = 2'b10
  } txd_state_t;

  typedef enum logic [1:0] {
    TXE_IDLE = 2'b01,
    TXE_READ = 2'b10
  } txe_state_t;

endpackage : hdlc_sched_pkg

`default_nettype wire

/* core/sched_mem.sv */
// Simple dual-port word memory with registered read data.
// Assumes one write and one read per cycle on the device clock.
`timescale 1ns/1ps
`default_nettype none

module sched_mem #(
  parameter int AW = 12,
  parameter int DW = 33
) (
  // Clock
  input wire logic sys_clk,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // Read port
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : sched_mem

`default_nettype wire

/* core/skid_buffer.sv */
// Two-entry buffer with valid and ready on both sides.
// Assumes a synchronous active-low reset on the device clock.
`timescale 1ns/1ps
`default_nettype none

module skid_buffer #(
  parameter int W = 42
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] slot0;
  logic [W-1:0] slot1;
  logic [1:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = slot0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      count <= 2'h0;
    end else begin
      count <= count + 2'(push) - 2'(pop);
    end
  end

  // Slot 0 is always the head; slot 1 shifts down on a pop.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      slot0 <= '0;
      slot1 <= '0;
    end else begin
      if (pop) begin
        slot0 <= (count == 2'h2) ? slot1 : in_data;
      end else if (push && count == 2'h0) begin
        slot0 <= in_data;
      end
      if (push && ((count == 2'h1 && !pop) || count == 2'h2)) begin
        slot1 <= in_data;
      end
    end
  end

endmodule : skid_buffer

`default_nettype wire

/* core/hdlc_fifo_transfer_scheduler.sv */
// Packet data path scheduler between the HDLC engines, the FIFO and the DMA.
// Assumes engines and DMA run on sys_clk and hold requests until served.
`timescale 1ns/1ps
`default_nettype none

module hdlc_fifo_transfer_scheduler
  import hdlc_sched_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Configuration
  input wire logic [FAST_PORTS-1:0] rx_port_control,
  input wire logic [FAST_PORTS-1:0] tx_port_control,
  input wire logic [LVL_W-1:0] rx_high_water,
  input wire logic [LVL_W-1:0] tx_low_water,
  input wire logic rx_sched_prio,
  input wire logic tx_sched_prio,
  input wire logic [NCHAN-1:0] tx_chan_en,
  // Receive standard engines
  input wire logic [NPORT-1:0] rx_std_req,
  input wire logic [WORD_W-1:0] rx_std_word [NPORT],
  input wire logic [CH_W-1:0] rx_std_chan [NPORT],
  input wire logic [NPORT-1:0] rx_std_eof,
  output logic [NPORT-1:0] rx_std_grant,
  // Receive fast engines
  input wire logic [FAST_PORTS-1:0] rx_fast_req,
  input wire logic [WORD_W-1:0] rx_fast_word [FAST_PORTS],
  input wire logic [CH_W-1:0] rx_fast_chan [FAST_PORTS],
  input wire logic [FAST_PORTS-1:0] rx_fast_eof,
  output logic [FAST_PORTS-1:0] rx_fast_grant,
  // Receive DMA stream
  output logic dma_rx_valid,
  input wire logic dma_rx_ready,
  output logic [WORD_W-1:0] dma_rx_data,
  output logic [CH_W-1:0] dma_rx_chan,
  output logic dma_rx_eof,
  output logic dma_rx_last,
  // Transmit engines
  input wire logic [NPORT-1:0] tx_std_req,
  input wire logic [CH_W-1:0] tx_std_chan [NPORT],
  input wire logic [FAST_PORTS-1:0] tx_fast_req,
  input wire logic [CH_W-1:0] tx_fast_chan [FAST_PORTS],
  output logic tx_byte_valid,
  output logic [BYTE_W-1:0] tx_byte,
  output logic [PORT_W-1:0] tx_byte_port,
  output logic tx_byte_fast,
  output logic [CH_W-1:0] tx_byte_chan,
  output logic tx_byte_last,
  // Transmit DMA
  output logic [NCHAN-1:0] tx_need,
  input wire logic [NCHAN-1:0] dma_tx_avail,
  output logic dma_tx_grant,
  output logic [CH_W-1:0] dma_tx_chan,
  input wire logic dma_tx_wvalid,
  output logic dma_tx_wready,
  input wire logic [WORD_W-1:0] dma_tx_wdata,
  input wire logic dma_tx_weof,
  input wire logic dma_tx_wlast
);

  // ----------------------------------------------------------------------
  // Arbitration helpers
  // ----------------------------------------------------------------------
  // Returns {found, index}; the lowest offset from the start point wins.
  function automatic logic [CH_W:0] pick_chan(
    input logic [NCHAN-1:0] pend,
    input logic [CH_W-1:0] last,
    input logic prio
  );
    logic [CH_W:0] res;
    logic [CH_W-1:0] idx;
    res = '0;
    for (int k = NCHAN - 1; k >= 0; k--) begin
      idx = prio ? CH_W'(k) : CH_W'(last + CH_W'(k) + CH_W'(1));
      if (pend[idx]) begin
        res = {1'b1, idx};
      end
    end
    return res;
  endfunction : pick_chan

  function automatic logic [PORT_W:0] pick_port(input logic [NPORT-1:0] r);
    logic [PORT_W:0] res;
    res = '0;
    for (int p = NPORT - 1; p >= 0; p--) begin
      if (r[p]) begin
        res = {1'b1, PORT_W'(p)};
      end
    end
    return res;
  endfunction : pick_port

  // ----------------------------------------------------------------------
  // Receive side: engine to FIFO
  // ----------------------------------------------------------------------
  logic [LVL_W-1:0] rx_level [NCHAN];
  logic [LVL_W-1:0] rx_eofs [NCHAN];
  logic [PTR_W-1:0] rx_wptr [NCHAN];
  logic [PTR_W-1:0] rx_rptr [NCHAN];
  logic [NPORT-1:0] rx_req_sel;
  logic [NPORT-1:0] rx_eof_sel;
  logic [NPORT-1:0] rx_elig;
  logic [WORD_W-1:0] rx_word_sel [NPORT];
  logic [CH_W-1:0] rx_chan_sel [NPORT];
  logic [NPORT-1:0] rx_fast_on;
  logic [PORT_W:0] rx_win;
  logic rx_wr;
  logic [CH_W-1:0] rx_wchan;

  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      rx_fast_on[p] = (p < FAST_PORTS) ? rx_port_control[p % FAST_PORTS] : 1'b0;
      rx_req_sel[p] = rx_std_req[p];
      rx_eof_sel[p] = rx_std_eof[p];
      rx_word_sel[p] = rx_std_word[p];
      rx_chan_sel[p] = rx_std_chan[p];
      if (rx_fast_on[p]) begin
        rx_req_sel[p] = rx_fast_req[p % FAST_PORTS];
        rx_eof_sel[p] = rx_fast_eof[p % FAST_PORTS];
        rx_word_sel[p] = rx_fast_word[p % FAST_PORTS];
        rx_chan_sel[p] = rx_fast_chan[p % FAST_PORTS];
      end
      // A port whose channel region is full waits without losing its word.
      rx_elig[p] = rx_req_sel[p] &&
        (rx_level[rx_chan_sel[p]] != REGION_FULL);
    end
  end

  assign rx_win = pick_port(rx_elig);
  assign rx_wr = rx_win[PORT_W];
  assign rx_wchan = rx_chan_sel[rx_win[PORT_W-1:0]];

  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      rx_std_grant[p] = rx_wr && (rx_win[PORT_W-1:0] == PORT_W'(p)) &&
        !rx_fast_on[p];
    end
    for (int f = 0; f < FAST_PORTS; f++) begin
      rx_fast_grant[f] = rx_wr && (rx_win[PORT_W-1:0] == PORT_W'(f)) &&
        rx_fast_on[f];
    end
  end

  // ----------------------------------------------------------------------
  // Receive side: FIFO to DMA
  // ----------------------------------------------------------------------
  rxd_state_t rxd_state;
  logic [CH_W-1:0] rx_dma_chan;
  logic [CH_W-1:0] rx_last_pick;
  logic [LVL_W-1:0] rx_left;
  logic [BURST_W-1:0] rx_burst_cnt;
  logic rx_inflight;
  logic rx_rd_last;
  logic rx_issue;
  logic rx_issue_last;
  logic [NCHAN-1:0] rx_pend;
  logic [CH_W:0] rx_pick;
  logic [MEM_DW-1:0] rx_rdata;
  logic buf_in_ready;
  logic [RXBUF_W-1:0] buf_out;

  always_comb begin
    for (int i = 0; i < NCHAN; i++) begin
      rx_pend[i] = (rx_level[i] > rx_high_water) ||
        (rx_eofs[i] != LEVEL_RST);
    end
  end

  assign rx_pick = pick_chan(rx_pend, rx_last_pick, rx_sched_prio);
  // One read in flight keeps the two-entry buffer from overflowing.
  assign rx_issue = (rxd_state == RXD_BURST) && (rx_left != LEVEL_RST) &&
    !rx_inflight && buf_in_ready;
  assign rx_issue_last = (rx_left == LVL_W'(1)) ||
    (rx_burst_cnt == BURST_LAST);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rxd_state <= RXD_IDLE;
      rx_dma_chan <= '0;
      rx_last_pick <= '1;
      rx_left <= LEVEL_RST;
      rx_burst_cnt <= '0;
    end else begin
      unique case (rxd_state)
        RXD_IDLE: begin
          if (rx_pick[CH_W]) begin
            rx_dma_chan <= rx_pick[CH_W-1:0];
            rx_last_pick <= rx_pick[CH_W-1:0];
            rx_left <= rx_level[rx_pick[CH_W-1:0]];
            rx_burst_cnt <= '0;
            rxd_state <= RXD_BURST;
          end
        end
        RXD_BURST: begin
          if (rx_issue) begin
            rx_left <= rx_issue_last ? LEVEL_RST : rx_left - LVL_W'(1);
            rx_burst_cnt <= rx_burst_cnt + BURST_W'(1);
          end else if (rx_left == LEVEL_RST && !rx_inflight) begin
            rxd_state <= RXD_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rx_inflight <= 1'b0;
      rx_rd_last <= 1'b0;
    end else begin
      rx_inflight <= rx_issue;
      rx_rd_last <= rx_issue_last;
    end
  end

  // Per-channel receive bookkeeping; writes and reads may hit one channel.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      for (int i = 0; i < NCHAN; i++) begin
        rx_level[i] <= LEVEL_RST;
        rx_eofs[i] <= LEVEL_RST;
        rx_wptr[i] <= PTR_RST;
        rx_rptr[i] <= PTR_RST;
      end
    end else begin
      for (int i = 0; i < NCHAN; i++) begin
        rx_level[i] <= rx_level[i] + LVL_W'(rx_wr && rx_wchan == CH_W'(i)) -
          LVL_W'(rx_issue && rx_dma_chan == CH_W'(i));
        rx_eofs[i] <= rx_eofs[i] + LVL_W'(rx_wr && rx_wchan == CH_W'(i) &&
          rx_eof_sel[rx_win[PORT_W-1:0]]) - LVL_W'(rx_inflight &&
          rx_rdata[WORD_W] && rx_dma_chan == CH_W'(i));
        rx_wptr[i] <= rx_wptr[i] + PTR_W'(rx_wr && rx_wchan == CH_W'(i));
        rx_rptr[i] <= rx_rptr[i] + PTR_W'(rx_issue &&
          rx_dma_chan == CH_W'(i));
      end
    end
  end

  sched_mem #(.AW(MEM_AW), .DW(MEM_DW)) u_rx_mem (
    .sys_clk(sys_clk),
    .wr_en(rx_wr),
    .wr_addr({rx_wchan, rx_wptr[rx_wchan]}),
    .wr_data({rx_eof_sel[rx_win[PORT_W-1:0]], rx_word_sel[rx_win[PORT_W-1:0]]}),
    .rd_en(rx_issue),
    .rd_addr({rx_dma_chan, rx_rptr[rx_dma_chan]}),
    .rd_data(rx_rdata)
  );

  skid_buffer #(.W(RXBUF_W)) u_rx_buf (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .in_valid(rx_inflight),
    .in_ready(buf_in_ready),
    .in_data({rx_dma_chan, rx_rd_last, rx_rdata}),
    .out_valid(dma_rx_valid),
    .out_ready(dma_rx_ready),
    .out_data(buf_out)
  );

  assign dma_rx_data = buf_out[WORD_W-1:0];
  assign dma_rx_eof = buf_out[WORD_W];
  assign dma_rx_last = buf_out[MEM_DW];
  assign dma_rx_chan = buf_out[RXBUF_W-1:MEM_DW+1];

  // ----------------------------------------------------------------------
  // Transmit side: DMA to FIFO
  // ----------------------------------------------------------------------
  logic [LVL_W-1:0] tx_level [NCHAN];
  logic [LVL_W-1:0] tx_eofs [NCHAN];
  logic [PTR_W-1:0] tx_wptr [NCHAN];
  logic [PTR_W-1:0] tx_rptr [NCHAN];
  logic [BIDX_W-1:0] tx_bidx [NCHAN];
  logic [NCHAN-1:0] tx_chan_ready;
  txd_state_t txd_state;
  logic [CH_W-1:0] tx_last_pick;
  logic [BURST_W-1:0] tx_burst_cnt;
  logic [CH_W:0] tx_pick;
  logic tx_accept;

  always_comb begin
    for (int i = 0; i < NCHAN; i++) begin
      tx_need[i] = tx_chan_en[i] && (tx_level[i] < tx_low_water);
      tx_chan_ready[i] = (tx_level[i] != LEVEL_RST) &&
        ((tx_level[i] > tx_low_water) || (tx_eofs[i] != LEVEL_RST));
    end
  end

  assign tx_pick = pick_chan(tx_need & dma_tx_avail, tx_last_pick,
    tx_sched_prio);
  assign dma_tx_grant = (txd_state == TXD_BURST);
  assign dma_tx_wready = dma_tx_grant && (tx_level[dma_tx_chan] != REGION_FULL);
  assign tx_accept = dma_tx_wvalid && dma_tx_wready;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      txd_state <= TXD_IDLE;
      dma_tx_chan <= '0;
      tx_last_pick <= '1;
      tx_burst_cnt <= '0;
    end else begin
      unique case (txd_state)
        TXD_IDLE: begin
          if (tx_pick[CH_W]) begin
            dma_tx_chan <= tx_pick[CH_W-1:0];
            tx_last_pick <= tx_pick[CH_W-1:0];
            tx_burst_cnt <= '0;
            txd_state <= TXD_BURST;
          end
        end
        TXD_BURST: begin
          if (tx_accept) begin
            tx_burst_cnt <= tx_burst_cnt + BURST_W'(1);
            if (dma_tx_wlast || tx_burst_cnt == BURST_LAST) begin
              txd_state <= TXD_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Transmit side: FIFO to engine
  // ----------------------------------------------------------------------
  txe_state_t txe_state;
  logic [NPORT-1:0] tx_req_sel;
  logic [CH_W-1:0] tx_chan_sel [NPORT];
  logic [NPORT-1:0] tx_fast_on;
  logic [NPORT-1:0] tx_elig;
  logic [PORT_W:0] tx_win;
  logic [CH_W-1:0] txe_chan;
  logic [PORT_W-1:0] txe_port;
  logic txe_fast;
  logic tx_rd;
  logic tx_word_done;
  logic [MEM_DW-1:0] tx_rdata;
  logic [BIDX_W-1:0] txe_bidx;

  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      tx_fast_on[p] = (p < FAST_PORTS) ? tx_port_control[p % FAST_PORTS] : 1'b0;
      tx_req_sel[p] = tx_fast_on[p] ? tx_fast_req[p % FAST_PORTS] :
        tx_std_req[p];
      tx_chan_sel[p] = tx_fast_on[p] ? tx_fast_chan[p % FAST_PORTS] :
        tx_std_chan[p];
      tx_elig[p] = tx_req_sel[p] && tx_chan_ready[tx_chan_sel[p]];
    end
  end

  assign tx_win = pick_port(tx_elig);
  assign tx_rd = (txe_state == TXE_IDLE) && tx_win[PORT_W];
  assign txe_bidx = tx_bidx[txe_chan];
  assign tx_word_done = (txe_state == TXE_READ) && (txe_bidx == BIDX_LAST);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      txe_state <= TXE_IDLE;
      txe_chan <= '0;
      txe_port <= '0;
      txe_fast <= 1'b0;
    end else begin
      unique case (txe_state)
        TXE_IDLE: begin
          if (tx_rd) begin
            txe_port <= tx_win[PORT_W-1:0];
            txe_chan <= tx_chan_sel[tx_win[PORT_W-1:0]];
            txe_fast <= tx_fast_on[tx_win[PORT_W-1:0]];
            txe_state <= TXE_READ;
          end
        end
        TXE_READ: begin
          txe_state <= TXE_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      tx_byte_valid <= 1'b0;
      tx_byte <= '0;
      tx_byte_port <= '0;
      tx_byte_fast <= 1'b0;
      tx_byte_chan <= '0;
      tx_byte_last <= 1'b0;
    end else begin
      tx_byte_valid <= (txe_state == TXE_READ);
      if (txe_state == TXE_READ) begin
        tx_byte <= tx_rdata[BYTE_W*txe_bidx +: BYTE_W];
        tx_byte_port <= txe_port;
        tx_byte_fast <= txe_fast;
        tx_byte_chan <= txe_chan;
        tx_byte_last <= tx_word_done && tx_rdata[WORD_W];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      for (int i = 0; i < NCHAN; i++) begin
        tx_level[i] <= LEVEL_RST;
        tx_eofs[i] <= LEVEL_RST;
        tx_wptr[i] <= PTR_RST;
        tx_rptr[i] <= PTR_RST;
        tx_bidx[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NCHAN; i++) begin
        tx_level[i] <= tx_level[i] +
          LVL_W'(tx_accept && dma_tx_chan == CH_W'(i)) -
          LVL_W'(tx_word_done && txe_chan == CH_W'(i));
        tx_eofs[i] <= tx_eofs[i] + LVL_W'(tx_accept && dma_tx_weof &&
          dma_tx_chan == CH_W'(i)) - LVL_W'(tx_word_done &&
          tx_rdata[WORD_W] && txe_chan == CH_W'(i));
        tx_wptr[i] <= tx_wptr[i] + PTR_W'(tx_accept && dma_tx_chan == CH_W'(i));
        tx_rptr[i] <= tx_rptr[i] + PTR_W'(tx_word_done &&
          txe_chan == CH_W'(i));
        tx_bidx[i] <= tx_bidx[i] + BIDX_W'(txe_state == TXE_READ &&
          txe_chan == CH_W'(i));
      end
    end
  end

  sched_mem #(.AW(MEM_AW), .DW(MEM_DW)) u_tx_mem (
    .sys_clk(sys_clk),
    .wr_en(tx_accept),
    .wr_addr({dma_tx_chan, tx_wptr[dma_tx_chan]}),
    .wr_data({dma_tx_weof, dma_tx_wdata}),
    .rd_en(tx_rd),
    .rd_addr({tx_chan_sel[tx_win[PORT_W-1:0]],
      tx_rptr[tx_chan_sel[tx_win[PORT_W-1:0]]]}),
    .rd_data(tx_rdata)
  );

endmodule : hdlc_fifo_transfer_scheduler

`default_nettype wire

/* dv/hdlc_fifo_transfer_scheduler_chk.sv */
// Concurrent checks on the ports of the transfer scheduler.
// Assumes one sys_clk domain and a bind onto the top module.
`timescale 1ns/1ps
`default_nettype none

module sched_chk
  import hdlc_sched_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Receive side
  input wire logic [NPORT-1:0] rx_std_req,
  input wire logic [NPORT-1:0] rx_std_eof,
  input wire logic [NPORT-1:0] rx_std_grant,
  input wire logic dma_rx_valid,
  input wire logic dma_rx_ready,
  input wire logic [WORD_W-1:0] dma_rx_data,
  input wire logic dma_rx_eof,
  // Transmit side
  input wire logic tx_byte_valid,
  input wire logic [NCHAN-1:0] tx_chan_en,
  input wire logic [NCHAN-1:0] tx_need,
  input wire logic [NCHAN-1:0] dma_tx_avail,
  input wire logic dma_tx_grant,
  input wire logic [CH_W-1:0] dma_tx_chan,
  input wire logic dma_tx_wvalid,
  input wire logic dma_tx_wready,
  input wire logic dma_tx_wlast
);
  logic [NCHAN-1:0] pend_q;
  always_ff @(posedge sys_clk) pend_q <= tx_need & dma_tx_avail;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_eof_in; (rx_std_grant & rx_std_eof) != 16'h0000; endsequence
  sequence s_eof_out; dma_rx_valid && dma_rx_ready && dma_rx_eof; endsequence
  property p_eof; s_eof_in |-> ##[1:1000] s_eof_out; endproperty
  a_eof: assert property (p_eof) else $error("eof word not sent");
  property p_one_grant; $onehot0(rx_std_grant); endproperty
  a_one_grant: assert property (p_one_grant) else $error("grants");
  property p_grant_req; (rx_std_grant & ~rx_std_req) == 16'h0000; endproperty
  a_grant_req: assert property (p_grant_req) else $error("no req");
  property p_rx_hold;
    dma_rx_valid && !dma_rx_ready |=> dma_rx_valid && $stable(dma_rx_data);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("word lost");
  property p_tx_pulse; tx_byte_valid |=> !tx_byte_valid; endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("byte rate");
  property p_need_en; (tx_need & ~tx_chan_en) == '0; endproperty
  a_need_en: assert property (p_need_en) else $error("need off");
  property p_pick; $rose(dma_tx_grant) |-> pend_q[dma_tx_chan]; endproperty
  a_pick: assert property (p_pick) else $error("bad pick");
  property p_hold_chan;
    dma_tx_grant && $past(dma_tx_grant) |-> $stable(dma_tx_chan);
  endproperty
  a_hold_chan: assert property (p_hold_chan) else $error("chan moved");
  property p_burst_end;
    dma_tx_grant && dma_tx_wvalid && dma_tx_wready && dma_tx_wlast
      |=> !dma_tx_grant;
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("open burst");
endmodule : sched_chk

bind hdlc_fifo_transfer_scheduler sched_chk u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .rx_std_req(rx_std_req),
  .rx_std_eof(rx_std_eof), .rx_std_grant(rx_std_grant),
  .dma_rx_valid(dma_rx_valid), .dma_rx_ready(dma_rx_ready),
  .dma_rx_data(dma_rx_data), .dma_rx_eof(dma_rx_eof),
  .tx_byte_valid(tx_byte_valid), .tx_chan_en(tx_chan_en), .tx_need(tx_need),
  .dma_tx_avail(dma_tx_avail), .dma_tx_grant(dma_tx_grant),
  .dma_tx_chan(dma_tx_chan), .dma_tx_wvalid(dma_tx_wvalid),
  .dma_tx_wready(dma_tx_wready), .dma_tx_wlast(dma_tx_wlast));

`default_nettype wire

/* dv/dma_model.sv */
// Behavioural model of the DMA engine facing the scheduler.
// Assumes the scheduler samples on the rising edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none

module dma_model
  import hdlc_sched_pkg::*;
(
  // Clock and pacing
  input wire logic sys_clk,
  input wire logic slow,
  // Receive stream
  output logic rx_ready = 1'b1,
  // Transmit fetch
  input wire logic grant,
  input wire logic [CH_W-1:0] chan,
  input wire logic wready,
  output logic wvalid = 1'b0,
  output logic [WORD_W-1:0] wdata = 32'h0,
  output logic wlast = 1'b0
);
  logic [1:0] idx = 2'h0;
  logic took = 1'b0;
  logic nv;
  always @(posedge sys_clk) begin
    took <= wvalid && wready;
    if (wvalid && wready) idx <= idx + 2'h1;
  end
  // Each burst is four words, the last one closing a frame.
  always @(negedge sys_clk) begin
    rx_ready <= !slow || ($urandom_range(1) == 1);
    nv = (wvalid && !took) || (grant && (!slow || $urandom_range(1) == 1));
    wvalid <= nv;
    wlast <= (idx == 2'h3);
    wdata <= nv ? {8'h5A, chan, 8'h3C, 6'h00, idx} : ~wdata;
  end
endmodule : dma_model

`default_nettype wire

/* dv/hdlc_fifo_transfer_scheduler_tb_top.sv */
// Self-checking bench of the HDLC FIFO transfer scheduler.
// Assumes dma_model on the DMA side; the bench plays the engines.
`timescale 1ns/1ps
`default_nettype none

module hdlc_fifo_transfer_scheduler_tb_top;
  import hdlc_sched_pkg::*;
  logic sys_clk = 1'b0, rstn = 1'b0, slow = 1'b0, rprio = 1'b0, tprio = 1'b0;
  logic [1:0] rctl = 2'h0, fg;
  logic [LVL_W-1:0] hwm = 5'h04, lwm = 5'h00;
  logic [NCHAN-1:0] en = '0, need;
  logic [NPORT-1:0] rreq = 16'h0, reof = 16'h0, treq = 16'h0, sg, g, e;
  logic [WORD_W-1:0] rw [NPORT], fw [2], rd, wd;
  logic [CH_W-1:0] rc [NPORT], tc [NPORT], fc [2], ftc [2], rch, bch, dch;
  logic [BYTE_W-1:0] byt;
  logic [PORT_W-1:0] bport;
  logic rv, rdy, reo, rl, bv, bl, bf, dg, wv, wr, wl;
  int n_fail = 0, samples_checked = 0, nout = 0, nl = 0, ein = 0, eout = 0;
  int n4 = 0, n7 = 0, k;
  always #12.5 sys_clk = ~sys_clk;
  assign g = sg | {14'h0, fg};
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      fw[i] = rw[i];
      fc[i] = rc[i];
      ftc[i] = tc[i];
    end
  end
  hdlc_fifo_transfer_scheduler uut (
    .sys_clk(sys_clk), .rstn(rstn), .rx_port_control(rctl),
    .tx_port_control(2'h0), .rx_high_water(hwm), .tx_low_water(lwm),
    .rx_sched_prio(rprio), .tx_sched_prio(tprio), .tx_chan_en(en),
    .rx_std_req(rreq & ~{14'h0, rctl}), .rx_std_word(rw), .rx_std_chan(rc),
    .rx_std_eof(reof), .rx_std_grant(sg), .rx_fast_req(rreq[1:0] & rctl),
    .rx_fast_word(fw), .rx_fast_chan(fc), .rx_fast_eof(reof[1:0]),
    .rx_fast_grant(fg), .dma_rx_valid(rv), .dma_rx_ready(rdy),
    .dma_rx_data(rd), .dma_rx_chan(rch), .dma_rx_eof(reo), .dma_rx_last(rl),
    .tx_std_req(treq), .tx_std_chan(tc), .tx_fast_req(2'h0),
    .tx_fast_chan(ftc), .tx_byte_valid(bv), .tx_byte(byt),
    .tx_byte_port(bport), .tx_byte_fast(bf), .tx_byte_chan(bch),
    .tx_byte_last(bl), .tx_need(need), .dma_tx_avail(en), .dma_tx_grant(dg),
    .dma_tx_chan(dch), .dma_tx_wvalid(wv), .dma_tx_wready(wr),
    .dma_tx_wdata(wd), .dma_tx_weof(wl), .dma_tx_wlast(wl));
  dma_model dma (.sys_clk(sys_clk), .slow(slow), .rx_ready(rdy), .grant(dg),
    .chan(dch), .wready(wr), .wvalid(wv), .wdata(wd), .wlast(wl));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [7:0] exp_byte(input logic [7:0] ch, input int n);
    logic [31:0] w;
    w = {8'h5A, ch, 8'h3C, 6'h00, n[3:2]};
    return w[8*n[1:0] +: 8];
  endfunction : exp_byte

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // Bytes are matched per port; the model repeats a four-word pattern.
  always @(posedge sys_clk) begin
    ein = ein + $countones(g & reof);
    if (rv && rdy) begin
      nout++;
      nl = nl + rl;
      eout = eout + reo;
      if (rc[2] == 8'hC8) check(rd, rw[2]);
      if (rc[2] == 8'hC8) check(rch, 8'hC8);
    end
    if (bv) begin
      k = (bport == 4'h7) ? n7 : n4;
      check({bf, bch, byt},
        {1'b0, tc[bport], exp_byte(tc[bport], k)});
      check(bl, k % 16 == 15);
      if (bport == 4'h7) check(n4 >= 16, 1);
      if (bport == 4'h7) n7++;
      else n4++;
    end
  end

  initial begin
    for (int i = 0; i < NPORT; i++) begin
      rw[i] = 32'h0;
      rc[i] = 8'h00;
      tc[i] = 8'h00;
    end
    void'($urandom(22));
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk) rstn = 1'b1;
    #1 check({dg, rv, bv, g}, 32'h0);
    $display("test reset done");
    for (int b = 0; b < 40; b++) begin
      @(negedge sys_clk);
      slow = b[0];
      rprio = b[1];
      rctl = 2'($urandom);
      reof = 16'($urandom);
      rreq = 16'($urandom);
      for (int i = 0; i < NPORT; i++) begin
        rw[i] = $urandom;
        rc[i] = 8'($urandom_range(127));
      end
      for (int n = 0; n < 16 && rreq != 16'h0; n++) begin
        e = rreq & (~rreq + 16'h1);
        #2 check(g, e);
        @(negedge sys_clk) rreq = rreq & ~e;
      end
      repeat (40) @(negedge sys_clk);
    end
    for (int n = 0; n < 3000 && eout != ein; n++) @(negedge sys_clk);
    check(eout, ein);
    if (eout != ein) report_and_stop();
    $display("test rx_priority done");
    slow = 1'b0;
    reof = 16'h0;
    repeat (100) @(negedge sys_clk);
    rc[2] = 8'hC8;
    nout = 0;
    nl = 0;
    for (int n = 0; n < 5; n++) begin
      if (n == 4) repeat (30) @(negedge sys_clk);
      if (n == 4) check(nout, 0);
      @(negedge sys_clk) rreq = 16'h0004;
      @(negedge sys_clk) rreq = 16'h0000;
    end
    repeat (30) @(negedge sys_clk);
    check({nout[7:0], nl[7:0]}, 16'h0501);
    $display("test rx_water_mark done");
    @(negedge sys_clk);
    lwm = 5'h02;
    tprio = 1'b1;
    en[11:10] = 2'h3;
    #2 check(need[11:10], 2'h3);
    tc[4] = 8'h0A;
    tc[7] = 8'h0B;
    treq = 16'h0090;
    for (int n = 0; n < 100 && !dg; n++) @(negedge sys_clk);
    check(dch, 8'h0A);
    if (!dg) report_and_stop();
    for (int n = 0; n < 3000 && n7 < 16; n++) begin
      @(negedge sys_clk);
      if (n4 >= 16) treq[4] = 1'b0;
    end
    check(n7, 16);
    treq = 16'h0;
    $display("test tx_order done");
    report_and_stop();
  end
endmodule : hdlc_fifo_transfer_scheduler_tb_top

`default_nettype wire
